// [plc_pkg.sv]
// shared types and constants for the loop-control datapath
`default_nettype none
package plc_pkg;
    localparam int unsigned XLEN = 64;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned VEC_BYTES = 16;
    localparam int unsigned LATENCY = 1;

    // element-count constraint encodings
    localparam logic [4:0] PAT_POW2 = 5'h00;
    localparam logic [4:0] PAT_VL1 = 5'h01;
    localparam logic [4:0] PAT_VL8 = 5'h08;
    localparam logic [4:0] PAT_VL16 = 5'h09;
    localparam logic [4:0] PAT_VL256 = 5'h0d;
    localparam logic [4:0] PAT_MUL4 = 5'h1d;
    localparam logic [4:0] PAT_MUL3 = 5'h1e;
    localparam logic [4:0] PAT_ALL = 5'h1f;
    localparam logic [15:0] VL16_COUNT = 16'h0010;

    typedef enum logic [1:0] {
        ESZ_BYTE,
        ESZ_HALF,
        ESZ_WORD,
        ESZ_DWORD
    } plc_esize_type;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_DEC_CNT,
        OP_INC_CNT,
        OP_DEC_TRUE,
        OP_INC_TRUE,
        OP_LOOP_SLE,
        OP_LOOP_ULO,
        OP_LOOP_ULS,
        OP_LOOP_SLT,
        OP_BRK_AFTER,
        OP_BRK_BEFORE,
        OP_PBRK_AFTER,
        OP_PBRK_BEFORE,
        OP_BRK_NEXT,
        OP_SET_FIRST,
        OP_FIND_NEXT,
        OP_CTERM_EQ,
        OP_CTERM_NE
    } plc_op_type;

    typedef struct packed {
        plc_op_type    op;
        plc_esize_type esize;
        logic          vector;
        logic          set_flags;
        logic [4:0]    pattern;
        logic [3:0]    mult;
        logic [63:0]   a;
        logic [63:0]   b;
    } plc_req_type;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } plc_flags_type;
endpackage
`default_nettype wire

// [plc_regfile_model.sv]
// issue-side register file model: condition flags and last predicate
`timescale 1ns/1ps
`default_nettype none
module plc_regfile_model (
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   res_valid,
    input  wire logic                   flags_we,
    input  wire plc_pkg::plc_flags_type flags,
    input  wire logic [15:0]            res_pred,
    output plc_pkg::plc_flags_type      flags_q,
    output logic [15:0]                 pred_q
);
    // flags only change when the datapath says it wrote them
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            flags_q <= '0;
        else if (flags_we)
            flags_q <= flags;
    end

    // earlier result kept as a ready-made partition operand
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            pred_q <= '0;
        else if (res_valid)
            pred_q <= res_pred;
    end
endmodule
`default_nettype wire

// [plc_sat.sv]
// unsigned saturating add or subtract of a count, one lane
`timescale 1ns/1ps
`default_nettype none
module plc_sat #(
    parameter int unsigned W = 64
) (
    input  wire logic [W-1:0]               a,
    input  wire logic [plc_pkg::CNT_W-1:0]  delta,
    input  wire logic                       dec,
    output logic [W-1:0]                    y
);
    logic [W:0] wide_delta;
    logic [W:0] sum;
    logic [W:0] diff;

    assign wide_delta = (W+1)'(delta);
    assign sum = {1'b0, a} + wide_delta;
    assign diff = {1'b0, a} - wide_delta;
    // borrow or carry out of the lane means clamp
    assign y = dec ? (diff[W] ? '0 : diff[W-1:0])
                   : (sum[W] ? '1 : sum[W-1:0]);
endmodule
`default_nettype wire

// [plc_top.sv]
// loop-control, counting and partition predicate datapath
`timescale 1ns/1ps
`default_nettype none
module plc_top #(
    parameter int unsigned VB = plc_pkg::VEC_BYTES
) (
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    input  wire logic                  req_valid,
    input  wire plc_pkg::plc_req_type  req,
    input  wire logic [VB*8-1:0]       vec_in,
    input  wire logic [VB-1:0]         gov_pred,
    input  wire logic [VB-1:0]         src1_pred,
    input  wire logic [VB-1:0]         src2_pred,
    input  wire plc_pkg::plc_flags_type flags_in,
    output logic                       res_valid,
    output logic [63:0]                res_scalar,
    output logic [VB*8-1:0]            res_vec,
    output logic [VB-1:0]              res_pred,
    output logic                       flags_we,
    output plc_pkg::plc_flags_type     flags
);
    localparam int unsigned PW = VB;
    localparam int unsigned CW = plc_pkg::CNT_W;

    logic [1:0]              esz;
    logic [PW-1:0]           emask;
    logic [CW-1:0]           n_elem;
    logic [CW-1:0]           cnt;
    logic [CW-1:0]           cnt_mul;
    logic [CW-1:0]           true_cnt;
    logic [CW-1:0]           delta;
    logic                    is_dec;
    logic [63:0]             sat_scalar;
    logic [VB*8-1:0]         vec_h;
    logic [VB*8-1:0]         vec_w;
    logic [VB*8-1:0]         vec_d;
    logic [PW-1:0]           lp_pred;
    logic                    lp_ok;
    logic                    lp_cmp;
    logic [64:0]             ua;
    logic [64:0]             ub;
    logic [PW-1:0]           ge;
    logic                    term;
    logic                    seen;
    logic [PW-1:0]           next_pred;
    logic [PW-1:0]           next_gov;
    logic [63:0]             next_scalar;
    logic [VB*8-1:0]         next_vec;
    logic                    next_fwe;
    plc_pkg::plc_flags_type  next_flags;
    plc_pkg::plc_req_type    req_q;
    logic [PW-1:0]           gov_q;

    // nzcv from a result under its governing predicate
    function automatic plc_pkg::plc_flags_type pred_flags(
        input logic [PW-1:0] r,
        input logic [PW-1:0] g
    );
        plc_pkg::plc_flags_type f;
        logic                   hit;
        f = '0;
        hit = 1'b0;
        f.c = 1'b1;
        for (int i = 0; i < PW; i++)
        begin
            if (g[i])
            begin
                if (!hit)
                    f.n = r[i];
                hit = 1'b1;
                f.c = ~r[i];
            end
        end
        f.z = ~|(r & g);
        return f;
    endfunction

    function automatic logic last_true(
        input logic [PW-1:0] p,
        input logic [PW-1:0] g
    );
        logic t;
        t = 1'b0;
        for (int i = 0; i < PW; i++)
        begin
            if (g[i])
                t = p[i];
        end
        return t;
    endfunction

    // one-bit elements; before drops the breaking element
    function automatic logic [PW-1:0] brk(
        input logic [PW-1:0] s,
        input logic [PW-1:0] g,
        input logic          excl
    );
        logic [PW-1:0] d;
        logic          hit;
        d = '0;
        hit = 1'b0;
        for (int i = 0; i < PW; i++)
        begin
            if (excl && g[i] && s[i])
                hit = 1'b1;
            d[i] = g[i] & ~hit;
            if (g[i] && s[i])
                hit = 1'b1;
        end
        return d;
    endfunction

    function automatic logic [CW-1:0] pattern_count(
        input logic [4:0]    pat,
        input logic [CW-1:0] n
    );
        logic [CW-1:0] k;
        k = '0;
        if (pat == plc_pkg::PAT_POW2)
        begin
            for (int j = 0; j < CW; j++)
            begin
                if ((16'h0001 << j) <= n)
                    k = 16'h0001 << j;
            end
        end
        else if (pat >= plc_pkg::PAT_VL1 && pat <= plc_pkg::PAT_VL8)
            k = (n >= CW'(pat)) ? CW'(pat) : '0;
        else if (pat >= plc_pkg::PAT_VL16 && pat <= plc_pkg::PAT_VL256)
        begin
            k = plc_pkg::VL16_COUNT << (pat - plc_pkg::PAT_VL16);
            k = (n >= k) ? k : '0;
        end
        else if (pat == plc_pkg::PAT_MUL4)
            k = n & ~16'h0003;
        else if (pat == plc_pkg::PAT_MUL3)
            k = n - (n % 16'h0003);
        else if (pat == plc_pkg::PAT_ALL)
            k = n;
        return k;
    endfunction

    // element granularity and counts
    always_comb
    begin
        esz = req.esize;
        n_elem = CW'(PW >> esz);
        for (int i = 0; i < PW; i++)
            emask[i] = (i % (1 << esz)) == 0;
        cnt = pattern_count(req.pattern, n_elem);
        cnt_mul = CW'(cnt * ({12'h000, req.mult} + 16'h0001));
        true_cnt = '0;
        for (int i = 0; i < PW; i++)
            true_cnt = true_cnt
                + CW'(gov_pred[i] & src1_pred[i] & emask[i]);
        delta = (req.op == plc_pkg::OP_DEC_TRUE
              || req.op == plc_pkg::OP_INC_TRUE) ? true_cnt : cnt_mul;
        is_dec = req.op == plc_pkg::OP_DEC_CNT
              || req.op == plc_pkg::OP_DEC_TRUE;
    end

    plc_sat #(.W(64)) u_sat_scalar (
        .a     (req.a),
        .delta (delta),
        .dec   (is_dec),
        .y     (sat_scalar)
    );

    // one saturating lane per element of the half, word and dword sizes; byte elements have no lane
    for (genvar h = 0; h < VB / 2; h++)
    begin : g_half
        plc_sat #(.W(16)) u_lane (
            .a     (vec_in[h*16 +: 16]),
            .delta (delta),
            .dec   (is_dec),
            .y     (vec_h[h*16 +: 16])
        );
    end
    for (genvar w = 0; w < VB / 4; w++)
    begin : g_word
        plc_sat #(.W(32)) u_lane (
            .a     (vec_in[w*32 +: 32]),
            .delta (delta),
            .dec   (is_dec),
            .y     (vec_w[w*32 +: 32])
        );
    end
    for (genvar d = 0; d < VB / 8; d++)
    begin : g_dword
        plc_sat #(.W(64)) u_lane (
            .a     (vec_in[d*64 +: 64]),
            .delta (delta),
            .dec   (is_dec),
            .y     (vec_d[d*64 +: 64])
        );
    end

    // counted loop; 65-bit compare so the index never wraps
    always_comb
    begin
        lp_pred = '0;
        lp_ok = 1'b1;
        lp_cmp = 1'b0;
        ua = '0;
        ub = '0;
        for (int i = 0; i < PW; i++)
        begin
            if (emask[i])
            begin
                if (req.op == plc_pkg::OP_LOOP_SLE
                    || req.op == plc_pkg::OP_LOOP_SLT)
                begin
                    ua = {req.a[63], req.a} + 65'(i >> esz);
                    ub = {req.b[63], req.b};
                    lp_cmp = (req.op == plc_pkg::OP_LOOP_SLE)
                        ? ($signed(ua) <= $signed(ub))
                        : ($signed(ua) < $signed(ub));
                end
                else
                begin
                    ua = {1'b0, req.a} + 65'(i >> esz);
                    ub = {1'b0, req.b};
                    lp_cmp = (req.op == plc_pkg::OP_LOOP_ULS)
                        ? (ua <= ub) : (ua < ub);
                end
                lp_ok = lp_ok & lp_cmp;
                lp_pred[i] = lp_ok;
            end
        end
    end

    // operation select
    always_comb
    begin
        next_pred = '0;
        next_gov = gov_pred;
        next_scalar = req.a;
        next_vec = vec_in;
        next_fwe = 1'b0;
        next_flags = flags_in;
        ge = gov_pred & emask;
        term = 1'b0;
        seen = 1'b0;
        case (req.op)
            plc_pkg::OP_DEC_CNT,
            plc_pkg::OP_INC_CNT,
            plc_pkg::OP_DEC_TRUE,
            plc_pkg::OP_INC_TRUE:
            begin
                if (!req.vector)
                    next_scalar = sat_scalar;
                else if (esz == plc_pkg::ESZ_HALF)
                    next_vec = vec_h;
                else if (esz == plc_pkg::ESZ_WORD)
                    next_vec = vec_w;
                else if (esz == plc_pkg::ESZ_DWORD)
                    next_vec = vec_d;
            end
            plc_pkg::OP_LOOP_SLE,
            plc_pkg::OP_LOOP_ULO,
            plc_pkg::OP_LOOP_ULS,
            plc_pkg::OP_LOOP_SLT:
            begin
                next_pred = lp_pred;
                next_gov = emask;
                next_fwe = 1'b1;
            end
            plc_pkg::OP_BRK_AFTER,
            plc_pkg::OP_BRK_BEFORE:
            begin
                next_pred = brk(src1_pred, gov_pred,
                    req.op == plc_pkg::OP_BRK_BEFORE);
                next_fwe = req.set_flags;
            end
            plc_pkg::OP_PBRK_AFTER,
            plc_pkg::OP_PBRK_BEFORE:
            begin
                if (last_true(src1_pred, gov_pred))
                    next_pred = brk(src2_pred, gov_pred,
                        req.op == plc_pkg::OP_PBRK_BEFORE);
                next_fwe = req.set_flags;
            end
            plc_pkg::OP_BRK_NEXT:
            begin
                if (last_true(src1_pred, gov_pred))
                    next_pred = src2_pred;
                next_fwe = req.set_flags;
            end
            plc_pkg::OP_SET_FIRST:
            begin
                next_pred = src1_pred;
                for (int i = 0; i < PW; i++)
                begin
                    if (gov_pred[i] && !seen)
                    begin
                        next_pred[i] = 1'b1;
                        seen = 1'b1;
                    end
                end
                next_fwe = 1'b1;
            end
            plc_pkg::OP_FIND_NEXT:
            begin
                // the last active true of the operand is current;
                // a later true element restarts the search past it
                for (int i = 0; i < PW; i++)
                begin
                    if (ge[i] && src1_pred[i])
                    begin
                        next_pred = '0;
                        seen = 1'b0;
                    end
                    else if (ge[i] && !seen)
                    begin
                        next_pred[i] = 1'b1;
                        seen = 1'b1;
                    end
                end
                next_gov = ge;
                next_fwe = 1'b1;
            end
            plc_pkg::OP_CTERM_EQ,
            plc_pkg::OP_CTERM_NE:
            begin
                term = (req.op == plc_pkg::OP_CTERM_EQ)
                    ? (req.a == req.b) : (req.a != req.b);
                next_flags.n = term;
                next_flags.v = ~term & ~flags_in.c;
                next_fwe = 1'b1;
            end
            default:
            begin
                next_fwe = 1'b0;
            end
        endcase
        if (req.op != plc_pkg::OP_CTERM_EQ
            && req.op != plc_pkg::OP_CTERM_NE)
            next_flags = pred_flags(next_pred, next_gov);
    end

    // result handshake and flags
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            res_valid <= 1'b0;
            flags_we <= 1'b0;
            flags <= '0;
        end
        else
        begin
            res_valid <= req_valid;
            flags_we <= req_valid & next_fwe;
            if (req_valid)
                flags <= next_flags;
        end
    end

    // result data, held until the next request
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            res_scalar <= '0;
            res_vec <= '0;
            res_pred <= '0;
            req_q <= '0;
            gov_q <= '0;
        end
        else if (req_valid)
        begin
            res_scalar <= next_scalar;
            res_vec <= next_vec;
            res_pred <= next_pred;
            req_q <= req;
            gov_q <= next_gov;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_flag_result;
        res_valid && flags_we;
    endsequence
    sequence s_loop_issue;
        req_valid && (req.op == plc_pkg::OP_LOOP_SLE
            || req.op == plc_pkg::OP_LOOP_ULO
            || req.op == plc_pkg::OP_LOOP_ULS
            || req.op == plc_pkg::OP_LOOP_SLT);
    endsequence
    sequence s_cterm_hit;
        req_valid && req.op == plc_pkg::OP_CTERM_EQ && req.a == req.b;
    endsequence

    dec_floor_a: assert property (
        res_valid && req_q.op == plc_pkg::OP_DEC_CNT && !req_q.vector
        |-> res_scalar <= req_q.a)
        else $error("saturating decrement rose above its operand");
    inc_ceil_a: assert property (
        res_valid && req_q.op == plc_pkg::OP_INC_CNT && !req_q.vector
        |-> res_scalar >= req_q.a)
        else $error("saturating increment wrapped");
    loop_flags_a: assert property (
        s_loop_issue |=> s_flag_result)
        else $error("counted loop left flags unwritten");
    lo_empty_a: assert property (
        req_valid && req.op == plc_pkg::OP_LOOP_ULO && req.a >= req.b
        |=> res_pred == '0)
        else $error("lower loop with start at limit not empty");
    break_quiet_a: assert property (
        req_valid && req.op == plc_pkg::OP_BRK_AFTER && !req.set_flags
        |=> res_valid && !flags_we)
        else $error("no-flag break wrote flags");
    part_within_a: assert property (
        res_valid && req_q.op inside {plc_pkg::OP_LOOP_SLT,
            plc_pkg::OP_BRK_AFTER, plc_pkg::OP_BRK_BEFORE}
        |-> (res_pred & ~gov_q) == '0)
        else $error("partition true outside active elements");
    break_to_next_partition_clear_a: assert property (
        req_valid && req.op == plc_pkg::OP_BRK_NEXT
        && !last_true(src1_pred, gov_pred) |=> res_pred == '0)
        else $error("next-partition break kept destination");
    zero_flag_a: assert property (
        s_flag_result ##0 (req_q.op != plc_pkg::OP_CTERM_EQ
            && req_q.op != plc_pkg::OP_CTERM_NE)
        |-> !flags.v && flags.z == ~|(res_pred & gov_q))
        else $error("predicate flags disagree with result");
    cterm_hit_a: assert property (
        s_cterm_hit |=> s_flag_result ##0 flags.n)
        else $error("equal compare did not signal termination");
endmodule
`default_nettype wire

// [predicate_loop_control_bench.sv]
// self-checking bench for the loop-control datapath
`timescale 1ns/1ps
`default_nettype none
module predicate_loop_control_bench;
    logic                   mclk, reset_n, req_valid, res_valid, flags_we;
    logic                   pend, zchk, e_we;
    plc_pkg::plc_req_type   req;
    plc_pkg::plc_flags_type flags_in, flags, e_flags;
    logic [127:0]           vec_in, res_vec, e_vec;
    logic [15:0]            gov_pred, src1_pred, src2_pred, res_pred;
    logic [15:0]            prev_pred, e_pred;
    logic [63:0]            res_scalar, e_scalar;
    logic [2:0]             mask;
    int                     error_cnt, samples_checked, seed, k;

    plc_top #(.VB(16)) uut (.mclk(mclk), .reset_n(reset_n),
        .req_valid(req_valid), .req(req), .vec_in(vec_in),
        .gov_pred(gov_pred), .src1_pred(src1_pred), .src2_pred(src2_pred),
        .flags_in(flags_in), .res_valid(res_valid), .res_scalar(res_scalar),
        .res_vec(res_vec), .res_pred(res_pred), .flags_we(flags_we),
        .flags(flags));
    plc_regfile_model rf (.mclk(mclk), .reset_n(reset_n),
        .res_valid(res_valid), .flags_we(flags_we), .flags(flags),
        .res_pred(res_pred), .flags_q(flags_in), .pred_q(prev_pred));

    always #12.5 mclk = ~mclk;

    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cmp(logic [127:0] got, logic [127:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic plc_pkg::plc_flags_type fl(logic [15:0] r, act);
        plc_pkg::plc_flags_type f;
        f = 4'b0110;
        for (int i = 15; i >= 0; i--)
            if (act[i]) f.n = r[i];
        for (int i = 0; i < 16; i++)
            if (act[i]) f.c = !r[i];
        f.z = (r & act) == 16'h0000;
        return f;
    endfunction

    function automatic int cons(int p, int n);
        int pw;
        pw = 1;
        while (pw * 2 <= n) pw = pw * 2;
        return p == 0 ? pw : (p >= 1 && p <= 8) ? (p <= n ? p : 0) :
            (p >= 9 && p <= 13) ? ((16 << (p - 9)) <= n ? 16 << (p - 9) : 0) :
            p == 29 ? n - n % 4 : p == 30 ? n - n % 3 : p == 31 ? n : 0;
    endfunction

    function automatic logic [63:0] sat(logic [63:0] x, int d, int w, bit dn);
        logic [63:0] mx;
        mx = (w == 64) ? '1 : (64'h1 << w) - 64'h1;
        if (dn) return (x < 64'(d)) ? '0 : x - 64'(d);
        return (x > mx - 64'(d)) ? mx : x + 64'(d);
    endfunction

    // op numbers follow the enum declaration order
    task automatic model();
        int o, n, d, w, hi;
        logic [15:0] el, r, src;
        logic [64:0] ea, eb;
        logic sg, dn, hold, fnd, lt, c, term;
        o = req.op;
        n = 16 >> req.esize;
        w = 8 << req.esize;
        el = '0; r = '0; fnd = 0; lt = 0; hold = 1; hi = -1;
        for (int i = 0; i < 16; i++)
        begin
            el[i] = (i % (16 / n)) == 0;
            if (gov_pred[i]) lt = src1_pred[i];
            if (gov_pred[i] && el[i] && src1_pred[i]) hi = i;
        end
        e_scalar = req.a; e_vec = vec_in; e_we = 0; mask = 3'b111;
        e_flags = '0;
        dn = o == 1 || o == 3;
        d = o < 3 ? cons(req.pattern, n) * (req.mult + 1) :
            $countones(gov_pred & src1_pred & el);
        src = (o == 9 || o == 10) ? src1_pred : src2_pred;
        case (o) inside
        [1:4]:
            if (req.vector)
            begin
                mask = 3'b010;
                if (w > 8)
                begin
                    e_vec = '0;
                    for (int i = 0; i < n; i++)
                        e_vec |= 128'(sat(64'(vec_in >> (i * w)) &
                            sat('1, 0, w, 0), d, w, dn)) << (i * w);
                end
            end
            else
            begin
                mask = 3'b001;
                e_scalar = sat(req.a, d, 64, dn);
            end
        [5:8]:
        begin
            sg = o == 5 || o == 8;
            eb = {sg & req.b[63], req.b};
            for (int i = 0; i < n; i++)
            begin
                ea = {sg & req.a[63], req.a} + 65'(i);
                c = o == 5 ? $signed(ea) <= $signed(eb) : o == 6 ? ea < eb :
                    o == 7 ? ea <= eb : $signed(ea) < $signed(eb);
                hold = hold & c;
                r[i * (16 / n)] = hold;
            end
            e_we = 1; e_flags = fl(r, el); mask = 3'b100;
        end
        [9:13]:
        begin
            for (int i = 0; i < 16; i++)
                if (gov_pred[i])
                begin
                    if ((o == 10 || o == 12) && src[i]) fnd = 1;
                    r[i] = !fnd;
                    if (src[i]) fnd = 1;
                end
            if ((o == 11 || o == 12) && !lt) r = '0;
            if (o == 13) r = lt ? src2_pred : '0;
            e_we = req.set_flags; e_flags = fl(r, gov_pred); mask = 3'b100;
        end
        14:
        begin
            r = src1_pred;
            for (int i = 0; i < 16; i++)
                if (gov_pred[i] && !fnd)
                begin
                    r[i] = 1; fnd = 1;
                end
            e_we = 1; e_flags = fl(r, gov_pred); mask = 3'b100;
        end
        15:
        begin
            for (int i = 0; i < 16; i++)
                if (gov_pred[i] && el[i] && i > hi && !fnd)
                begin
                    r[i] = 1; fnd = 1;
                end
            e_we = 1; e_flags = fl(r, gov_pred & el); mask = 3'b100;
        end
        [16:17]:
        begin
            term = (req.a == req.b) ^ (o == 17);
            e_flags = {term, flags_in.z, flags_in.c, !term && !flags_in.c};
            e_we = 1; mask = 3'b000;
        end
        default: ;
        endcase
        e_pred = r;
    endtask

    function automatic logic [63:0] pick();
        case ($urandom_range(0, 3))
            0: return 64'($urandom_range(0, 40));
            1: return '1 - 64'($urandom_range(0, 40));
            2: return {$urandom, $urandom};
            default: return 64'h8000_0000_0000_0000 - 64'($urandom_range(0, 20));
        endcase
    endfunction

    task automatic drive(int k);
        req.op = plc_pkg::plc_op_type'(k < 18 ? k : $urandom_range(0, 17));
        req.esize = plc_pkg::plc_esize_type'($urandom_range(0, 3));
        req.vector = 1'($urandom);
        req.set_flags = 1'($urandom);
        req.pattern = 5'($urandom);
        req.mult = 4'($urandom);
        req.a = pick();
        req.b = ($urandom % 3 == 0) ? pick() :
            req.a + 64'($urandom_range(0, 20)) - 64'h4;
        if (k == 18)
        begin
            req.op = plc_pkg::OP_LOOP_ULO; req.esize = plc_pkg::ESZ_BYTE;
            req.a = '0; req.b = 64'h3;
        end
        vec_in = {$urandom, $urandom, $urandom, $urandom};
        gov_pred = ($urandom % 4 == 0) ? 16'hffff : 16'($urandom);
        src1_pred = 16'($urandom & $urandom);
        src2_pred = (req.op == plc_pkg::OP_BRK_NEXT) ? prev_pred : 16'($urandom);
        model();
        req_valid = 1;
        pend = 1;
    endtask

    task automatic chk();
        if (zchk)
        begin
            cmp(res_pred, '0);
            cmp(res_scalar, '0);
            cmp(flags, '0);
        end
        cmp(res_valid, pend);
        if (pend)
        begin
            cmp(flags_we, e_we);
            if (e_we) cmp(flags, e_flags);
            if (mask[0]) cmp(res_scalar, e_scalar);
            if (mask[1]) cmp(res_vec, e_vec);
            if (mask[2]) cmp(res_pred, e_pred);
        end
    endtask

    initial
    begin
        mclk = 0; reset_n = 0; req_valid = 0; req = '0; vec_in = '0;
        gov_pred = '0; src1_pred = '0; src2_pred = '0; pend = 0; zchk = 1;
        error_cnt = 0; samples_checked = 0;
        seed = $urandom(32'h8d73);
        repeat (2) @(posedge mclk);
        for (k = 0; k < 1000; k++)
        begin
            @(negedge mclk);
            chk();
            zchk = k == 500;
            reset_n = k != 500;
            // a mid-run reset drops any result in flight
            if (k != 500 && (k < 19 || $urandom % 4 != 0))
                drive(k);
            else
            begin
                req_valid = 0;
                pend = 0;
            end
        end
        @(negedge mclk);
        chk();
        end_of_test();
    end

    initial
    begin
        repeat (2000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end
endmodule
`default_nettype wire
